// *** logic/acc_pkg.sv ***
// Constants shared by the comparator control block and its per-unit module
package acc_pkg;

  localparam int          ACC_NUM          = 3;
  localparam int          ACC_ADDR_W       = 8;
  localparam int          ACC_DATA_W       = 32;
  localparam int          ACC_CTRL_W       = 8;

  // Register byte offsets
  localparam logic [7:0]  ACC_OFS_CTRL1    = 8'h00;
  localparam logic [7:0]  ACC_OFS_CTRL2    = 8'h04;
  localparam logic [7:0]  ACC_OFS_CTRL3    = 8'h08;
  localparam logic [7:0]  ACC_OFS_STATUS   = 8'h0C;
  localparam logic [7:0]  ACC_OFS_FLAG     = 8'h10;
  localparam logic [7:0]  ACC_OFS_MASK     = 8'h14;

  // Control register field positions
  localparam int          ACC_BIT_ENABLE   = 7;
  localparam int          ACC_BIT_PIN_EN   = 6;
  localparam int          ACC_BIT_INVERT   = 5;
  localparam int          ACC_BIT_EVT_HI   = 4;
  localparam int          ACC_BIT_EVT_LO   = 3;
  localparam int          ACC_BIT_NONINV   = 2;
  localparam int          ACC_BIT_CH_HI    = 1;
  localparam int          ACC_BIT_CH_LO    = 0;

  // Reset values
  localparam logic [7:0]  ACC_CTRL_RST     = 8'h1F;
  localparam logic [2:0]  ACC_FLAG_RST     = 3'h0;
  localparam logic [2:0]  ACC_MASK_RST     = 3'h0;

  // Event edge select codes
  localparam logic [1:0]  ACC_EVT_NONE     = 2'h0;
  localparam logic [1:0]  ACC_EVT_RISE     = 2'h1;
  localparam logic [1:0]  ACC_EVT_FALL     = 2'h2;
  localparam logic [1:0]  ACC_EVT_ANY      = 2'h3;

  // Inverting channel select codes
  localparam logic [1:0]  ACC_CH_DEFAULT   = 2'h0;
  localparam logic [1:0]  ACC_CH_OWN_C     = 2'h1;
  localparam logic [1:0]  ACC_CH_SHARED_B  = 2'h2;
  localparam logic [1:0]  ACC_CH_BANDGAP   = 2'h3;

  // One-hot inverting source lines toward the analog mux
  localparam int          ACC_SRC_W        = 4;
  localparam int          ACC_SRC_OWN_C    = 0;
  localparam int          ACC_SRC_SHARED_B = 1;
  localparam int          ACC_SRC_D        = 2;
  localparam int          ACC_SRC_BANDGAP  = 3;
  localparam int          ACC_D_UNIT       = 1;

  // Bus responses
  localparam logic [1:0]  ACC_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  ACC_RESP_SLVERR  = 2'h2;

endpackage : acc_pkg

// *** logic/acc_unit_if.sv ***
// Signals between the control block and one comparator unit
`timescale 1ns/1ns
`default_nettype none

interface acc_unit_if;
  import acc_pkg::*;

  logic [ACC_CTRL_W-1:0] ctrl;
  logic                  raw;
  logic                  result;
  logic                  evt;
  logic                  pin;
  logic                  pin_oe;
  logic [ACC_SRC_W-1:0]  inv_sel;

  modport unit (
    input  ctrl,
    input  raw,
    output result,
    output evt,
    output pin,
    output pin_oe,
    output inv_sel
  );

  modport ctl (
    output ctrl,
    output raw,
    input  result,
    input  evt,
    input  pin,
    input  pin_oe,
    input  inv_sel
  );

endinterface : acc_unit_if

`default_nettype wire

// *** logic/acc_unit.sv ***
// One comparator: result sync, polarity, edge events, pin and input routing
`timescale 1ns/1ns
`default_nettype none

module acc_unit
  import acc_pkg::*;
#(
  parameter int UNIT_IDX = 0
)
(
  input wire logic clk,
  input wire logic rst,
  acc_unit_if.unit port
);

  logic       sync1;
  logic       sync2;
  logic       sync3;
  logic       stable;
  logic       next_result;
  logic [1:0] evt_sel;

  assign evt_sel = port.ctrl[ACC_BIT_EVT_HI:ACC_BIT_EVT_LO];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end
    else
    begin
      sync1 <= port.raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A change counts only once two later stages agree
  always_ff @(posedge clk)
  begin
    if (rst)
      stable <= 1'b0;
    else if (sync2 == sync3)
      stable <= sync3;
  end

  // Disabled comparator reads low whatever the polarity
  always_comb
  begin
    next_result = port.ctrl[ACC_BIT_ENABLE] & (stable ^ port.ctrl[ACC_BIT_INVERT]);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      port.result <= 1'b0;
      port.evt    <= 1'b0;
    end
    else
    begin
      port.result <= next_result;
      case (evt_sel)
        ACC_EVT_ANY:  port.evt <= next_result ^ port.result;
        ACC_EVT_RISE: port.evt <= next_result & ~port.result;
        ACC_EVT_FALL: port.evt <= ~next_result & port.result;
        default:      port.evt <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      port.pin    <= 1'b0;
      port.pin_oe <= 1'b0;
    end
    else
    begin
      port.pin    <= next_result & port.ctrl[ACC_BIT_PIN_EN];
      port.pin_oe <= port.ctrl[ACC_BIT_PIN_EN];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      port.inv_sel <= '0;
    else
    begin
      port.inv_sel <= '0;
      case (port.ctrl[ACC_BIT_CH_HI:ACC_BIT_CH_LO])
        ACC_CH_BANDGAP:  port.inv_sel[ACC_SRC_BANDGAP]  <= 1'b1;
        ACC_CH_SHARED_B: port.inv_sel[ACC_SRC_SHARED_B] <= 1'b1;
        ACC_CH_OWN_C:    port.inv_sel[ACC_SRC_OWN_C]    <= 1'b1;
        default:
        begin
          if (UNIT_IDX == ACC_D_UNIT)
            port.inv_sel[ACC_SRC_D] <= 1'b1;
          else
            port.inv_sel[ACC_SRC_SHARED_B] <= 1'b1;
        end
      endcase
    end
  end

endmodule : acc_unit

`default_nettype wire

// *** logic/acc_top.sv ***
// Three-comparator control block with AXI4-Lite register access
`timescale 1ns/1ns
`default_nettype none

module acc_top
  import acc_pkg::*;
(
  input  wire logic                    CLK,
  input  wire logic                    RST,
  // AXI4-Lite write address
  input  wire logic [ACC_ADDR_W-1:0]   AWADDR,
  input  wire logic [2:0]              AWPROT,
  input  wire logic                    AWVALID,
  output var  logic                    AWREADY,
  // AXI4-Lite write data
  input  wire logic [ACC_DATA_W-1:0]   WDATA,
  input  wire logic [3:0]              WSTRB,
  input  wire logic                    WVALID,
  output var  logic                    WREADY,
  // AXI4-Lite write response
  output var  logic [1:0]              BRESP,
  output var  logic                    BVALID,
  input  wire logic                    BREADY,
  // AXI4-Lite read address
  input  wire logic [ACC_ADDR_W-1:0]   ARADDR,
  input  wire logic [2:0]              ARPROT,
  input  wire logic                    ARVALID,
  output var  logic                    ARREADY,
  // AXI4-Lite read data
  output var  logic [ACC_DATA_W-1:0]   RDATA,
  output var  logic [1:0]              RRESP,
  output var  logic                    RVALID,
  input  wire logic                    RREADY,
  // Analog comparator cores
  input  wire logic [ACC_NUM-1:0]      COMPARATOR_RAW,
  output var  logic [ACC_NUM-1:0]      COMPARATOR_ENABLE,
  output var  logic [ACC_NUM-1:0]      NONINVERTING_SOURCE_SELECT,
  output var  logic [ACC_NUM*ACC_SRC_W-1:0] INVERTING_SOURCE_ONEHOT,
  // Remappable result pins
  output var  logic [ACC_NUM-1:0]      RESULT_OUTPUT_PIN,
  output var  logic [ACC_NUM-1:0]      RESULT_OUTPUT_PIN_OE,
  // Interrupt request
  output var  logic                    IRQ
);

  logic [ACC_CTRL_W-1:0] comparator_control [ACC_NUM];
  logic [ACC_NUM-1:0]    comparator_event_flag;
  logic [ACC_NUM-1:0]    event_mask;
  logic [ACC_NUM-1:0]    comparator_result_bits;
  logic [ACC_NUM-1:0]    unit_event;

  // Write channel state
  logic                  aw_full;
  logic                  w_full;
  logic [ACC_ADDR_W-1:0] aw_addr;
  logic [ACC_DATA_W-1:0] w_data;
  logic [3:0]            w_strb;
  logic                  aw_hit;
  logic                  w_hit;
  logic                  wr_fire;
  logic                  wr_lane0;
  logic [ACC_ADDR_W-1:0] wr_word;
  logic                  wr_mapped;
  logic                  next_aw_full;
  logic                  next_w_full;
  logic                  next_bvalid;

  // Read channel state
  logic                  ar_hit;
  logic                  next_rvalid;
  logic [ACC_ADDR_W-1:0] rd_word;
  logic [ACC_DATA_W-1:0] rd_data;
  logic                  rd_mapped;

  // Flag update terms
  logic [ACC_NUM-1:0]    ctrl_wr;
  logic [ACC_NUM-1:0]    any_mode_set;
  logic [ACC_NUM-1:0]    next_flag;

  // Register strobes from the write decode
  logic                  flag_wr;
  logic                  mask_wr;

  acc_unit_if u_if [ACC_NUM] ();

  // One unit per comparator, each fed only by its own control register
  generate
    for (genvar i = 0; i < ACC_NUM; i++)
    begin : g_unit
      acc_unit #(
        .UNIT_IDX (i)
      ) u_unit (
        .clk  (CLK),
        .rst  (RST),
        .port (u_if[i].unit)
      );

      assign u_if[i].ctrl = comparator_control[i];
      assign u_if[i].raw  = COMPARATOR_RAW[i];

      assign comparator_result_bits[i] = u_if[i].result;
      assign unit_event[i]             = u_if[i].evt;

      assign RESULT_OUTPUT_PIN[i]    = u_if[i].pin;
      assign RESULT_OUTPUT_PIN_OE[i] = u_if[i].pin_oe;

      assign INVERTING_SOURCE_ONEHOT[i*ACC_SRC_W +: ACC_SRC_W] = u_if[i].inv_sel;

      assign COMPARATOR_ENABLE[i]          = comparator_control[i][ACC_BIT_ENABLE];
      assign NONINVERTING_SOURCE_SELECT[i] = comparator_control[i][ACC_BIT_NONINV];
    end
  endgenerate

  // Write handshake: address and data are caught in either order
  always_comb
  begin
    aw_hit  = AWVALID & AWREADY;
    w_hit   = WVALID & WREADY;
    // Commit waits until the previous response has been taken
    wr_fire = aw_full & w_full & ~BVALID;

    if (aw_hit)
      next_aw_full = 1'b1;
    else if (wr_fire)
      next_aw_full = 1'b0;
    else
      next_aw_full = aw_full;

    if (w_hit)
      next_w_full = 1'b1;
    else if (wr_fire)
      next_w_full = 1'b0;
    else
      next_w_full = w_full;

    if (wr_fire)
      next_bvalid = 1'b1;
    else if (BVALID & BREADY)
      next_bvalid = 1'b0;
    else
      next_bvalid = BVALID;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= 4'h0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
    end
    else
    begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      if (aw_hit)
        aw_addr <= AWADDR;
      if (w_hit)
      begin
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      // Ready drops while a half is held or a response is pending
      AWREADY <= ~next_aw_full & ~next_bvalid;
      WREADY  <= ~next_w_full & ~next_bvalid;
      BVALID  <= next_bvalid;
    end
  end

  // Write decode
  always_comb
  begin
    wr_word   = {aw_addr[ACC_ADDR_W-1:2], 2'b00};
    wr_lane0  = w_strb[0];
    ctrl_wr   = '0;
    flag_wr   = 1'b0;
    mask_wr   = 1'b0;
    wr_mapped = 1'b1;
    if (wr_word == ACC_OFS_CTRL1)
      ctrl_wr[0] = wr_fire & wr_lane0;
    else if (wr_word == ACC_OFS_CTRL2)
      ctrl_wr[1] = wr_fire & wr_lane0;
    else if (wr_word == ACC_OFS_CTRL3)
      ctrl_wr[2] = wr_fire & wr_lane0;
    // Status is read-only: the write is answered OKAY and dropped
    else if (wr_word == ACC_OFS_STATUS)
      wr_mapped = 1'b1;
    else if (wr_word == ACC_OFS_FLAG)
    begin
      wr_mapped = 1'b1;
      flag_wr   = wr_fire & wr_lane0;
    end
    else if (wr_word == ACC_OFS_MASK)
    begin
      wr_mapped = 1'b1;
      mask_wr   = wr_fire & wr_lane0;
    end
    else
      wr_mapped = 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      BRESP <= ACC_RESP_OKAY;
    else if (wr_fire)
      BRESP <= wr_mapped ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
  end

  // Control registers, each written only through its own offset
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      for (int k = 0; k < ACC_NUM; k++)
        comparator_control[k] <= ACC_CTRL_RST;
    end
    else
    begin
      for (int k = 0; k < ACC_NUM; k++)
        if (ctrl_wr[k])
          comparator_control[k] <= w_data[ACC_CTRL_W-1:0];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      event_mask <= ACC_MASK_RST;
    else if (mask_wr)
      event_mask <= w_data[ACC_NUM-1:0];
  end

  // Flags: software writes the value, hardware sets win over a clear
  always_comb
  begin
    next_flag = comparator_event_flag;
    if (flag_wr)
      next_flag = w_data[ACC_NUM-1:0];
    for (int k = 0; k < ACC_NUM; k++)
    begin
      any_mode_set[k] = ctrl_wr[k] &&
                        w_data[ACC_BIT_EVT_HI:ACC_BIT_EVT_LO] == ACC_EVT_ANY;
    end
    next_flag = next_flag | unit_event | any_mode_set;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      comparator_event_flag <= ACC_FLAG_RST;
    else
      comparator_event_flag <= next_flag;
  end

  // The mask only gates the request line, never the flags
  always_ff @(posedge CLK)
  begin
    if (RST)
      IRQ <= 1'b0;
    else
      IRQ <= |(comparator_event_flag & event_mask);
  end

  // Read handshake: one read at a time, data registered with valid
  always_comb
  begin
    ar_hit = ARVALID & ARREADY;
    if (ar_hit)
      next_rvalid = 1'b1;
    else if (RVALID & RREADY)
      next_rvalid = 1'b0;
    else
      next_rvalid = RVALID;
  end

  // Read decode
  // Unmapped offsets read as zero with an error response
  always_comb
  begin
    rd_word   = {ARADDR[ACC_ADDR_W-1:2], 2'b00};
    rd_data   = '0;
    rd_mapped = 1'b1;
    if (rd_word == ACC_OFS_CTRL1)
      rd_data[ACC_CTRL_W-1:0] = comparator_control[0];
    else if (rd_word == ACC_OFS_CTRL2)
      rd_data[ACC_CTRL_W-1:0] = comparator_control[1];
    else if (rd_word == ACC_OFS_CTRL3)
      rd_data[ACC_CTRL_W-1:0] = comparator_control[2];
    else if (rd_word == ACC_OFS_STATUS)
      rd_data[ACC_NUM-1:0] = comparator_result_bits;
    else if (rd_word == ACC_OFS_FLAG)
      rd_data[ACC_NUM-1:0] = comparator_event_flag;
    else if (rd_word == ACC_OFS_MASK)
      rd_data[ACC_NUM-1:0] = event_mask;
    else
      rd_mapped = 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= '0;
      RRESP   <= ACC_RESP_OKAY;
    end
    else
    begin
      ARREADY <= ~next_rvalid;
      RVALID  <= next_rvalid;
      if (ar_hit)
      begin
        RDATA <= rd_data;
        RRESP <= rd_mapped ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
      end
    end
  end

endmodule : acc_top

`default_nettype wire

// *** tb/acc_analog_model.sv ***
// Behavioural model of the three analog comparator cores and their input sources
`timescale 1ns/1ns
`default_nettype none

module acc_analog_model
  import acc_pkg::*;
(
  input  wire logic [ACC_NUM-1:0]           enable,
  input  wire logic [ACC_NUM-1:0]           noninv_sel,
  input  wire logic [ACC_NUM*ACC_SRC_W-1:0] inv_onehot,
  // Levels: 0-2 own A, 3-5 own C, 6 shared B, 7 D, 8 bandgap, 9 internal ref
  input  wire logic [7:0]                   volt [10],
  output var  logic [ACC_NUM-1:0]           raw
);
  logic [7:0] vp [ACC_NUM];
  logic [7:0] vm [ACC_NUM];

  always_comb
  begin
    for (int i = 0; i < ACC_NUM; i++)
    begin
      vp[i] = noninv_sel[i] ? volt[9] : volt[i];
      vm[i] = inv_onehot[i*ACC_SRC_W+ACC_SRC_BANDGAP] ? volt[8] :
              inv_onehot[i*ACC_SRC_W+ACC_SRC_D] ? volt[7] :
              inv_onehot[i*ACC_SRC_W+ACC_SRC_SHARED_B] ? volt[6] : volt[3+i];
      // A powered-down core parks low, so only the enabled path can make edges
      raw[i] = enable[i] && (vp[i] > vm[i]);
    end
  end
endmodule : acc_analog_model

`default_nettype wire

// *** tb/acc_top_assertions.sv ***
// Port-level assertions for the comparator control block
`timescale 1ns/1ns
`default_nettype none

module acc_top_assertions
  import acc_pkg::*;
(
  input wire logic                         CLK,
  input wire logic                         RST,
  input wire logic [ACC_ADDR_W-1:0]        ARADDR,
  input wire logic                         ARVALID,
  input wire logic                         ARREADY,
  input wire logic                         AWVALID,
  input wire logic                         AWREADY,
  input wire logic [ACC_DATA_W-1:0]        RDATA,
  input wire logic                         RVALID,
  input wire logic                         RREADY,
  input wire logic [1:0]                   BRESP,
  input wire logic                         BVALID,
  input wire logic                         BREADY,
  input wire logic [ACC_NUM-1:0]           COMPARATOR_ENABLE,
  input wire logic [ACC_NUM*ACC_SRC_W-1:0] INVERTING_SOURCE_ONEHOT,
  input wire logic [ACC_NUM-1:0]           RESULT_OUTPUT_PIN,
  input wire logic [ACC_NUM-1:0]           RESULT_OUTPUT_PIN_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  logic rd_status;

  always_ff @(posedge CLK)
    if (RST)
      rd_status <= 1'b0;
    else if (ARVALID && ARREADY)
      rd_status <= (ARADDR == ACC_OFS_STATUS);

  property p_pin_idle;
    (RESULT_OUTPUT_PIN_OE == 3'h0) [*3] |-> RESULT_OUTPUT_PIN == 3'h0;
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("result pin high while its output is off");

  property p_pin_disabled;
    (COMPARATOR_ENABLE == 3'h0) [*8] |-> RESULT_OUTPUT_PIN == 3'h0;
  endproperty
  a_pin_disabled: assert property (p_pin_disabled)
    else $error("result pin high with all comparators off");

  property p_src_onehot;
    !$past(RST) |-> $onehot(INVERTING_SOURCE_ONEHOT[3:0]) &&
      $onehot(INVERTING_SOURCE_ONEHOT[7:4]) && $onehot(INVERTING_SOURCE_ONEHOT[11:8]);
  endproperty
  a_src_onehot: assert property (p_src_onehot)
    else $error("inverting source select not one-hot");

  property p_no_d_odd;
    INVERTING_SOURCE_ONEHOT[2] == 1'b0 && INVERTING_SOURCE_ONEHOT[10] == 1'b0;
  endproperty
  a_no_d_odd: assert property (p_no_d_odd)
    else $error("D input routed to unit one or three");

  property p_status_width;
    RVALID && rd_status |-> RDATA[31:3] == 29'h0;
  endproperty
  a_status_width: assert property (p_status_width)
    else $error("status read with upper bits set");

  property p_aw_refused;
    AWVALID && AWREADY |=> !AWREADY;
  endproperty
  a_aw_refused: assert property (p_aw_refused)
    else $error("write address ready during a write");

  property p_b_hold;
    BVALID && !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before taken");

  property p_r_hold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped before taken");

  property p_r_latency;
    ARVALID && ARREADY |=> RVALID;
  endproperty
  a_r_latency: assert property (p_r_latency)
    else $error("read answer late");
endmodule : acc_top_assertions

`default_nettype wire

// *** tb/acc_top_bench.sv ***
// Self-checking bench for the comparator control block
`timescale 1ns/1ns
`default_nettype none

module acc_top_bench
  import acc_pkg::*;
;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [2:0]  raw, en, nsel, pin, oe;
  logic [11:0] onehot;
  logic [7:0]  volt [10];
  int          n_fail = 0;
  int          n_compared = 0;

  acc_top dut (.CLK(clk), .RST(rst), .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .COMPARATOR_RAW(raw), .COMPARATOR_ENABLE(en),
    .NONINVERTING_SOURCE_SELECT(nsel), .INVERTING_SOURCE_ONEHOT(onehot),
    .RESULT_OUTPUT_PIN(pin), .RESULT_OUTPUT_PIN_OE(oe), .IRQ(irq));
  acc_analog_model u_analog (.enable(en), .noninv_sel(nsel), .inv_onehot(onehot),
    .volt(volt), .raw(raw));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  task automatic stop_test();
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      aw_ok |= awready;
      w_ok |= wready;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    // Ready two edges late on purpose, so the response must stand while unanswered
    @(posedge clk);
    @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, exp);
    chk(32'(r), 32'(ACC_RESP_OKAY));
  endtask : rchk

  function automatic logic [7:0] cofs(input int u);
    return ACC_OFS_CTRL1 + 8'(4 * u);
  endfunction : cofs

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [3:0]  src;
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hF};
    foreach (volt[i]) volt[i] = 8'h40;
    volt[8] = 8'h80;
    volt[9] = 8'hC0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int u = 0; u < 3; u++) rchk(cofs(u), 32'h1F);
    rchk(ACC_OFS_STATUS, 32'h0);
    rchk(ACC_OFS_FLAG, 32'h0);
    rchk(ACC_OFS_MASK, 32'h0);
    chk(32'({en, nsel, oe}), 32'h38);
    for (int m = 0; m < 4; m++)
    begin
      wr(ACC_OFS_FLAG, 32'h0, ACC_RESP_OKAY);
      wr(ACC_OFS_CTRL1, 32'(8'h83 | 8'(m << 3)), ACC_RESP_OKAY);
      rchk(ACC_OFS_FLAG, 32'(m == 3));
      wr(ACC_OFS_FLAG, 32'h0, ACC_RESP_OKAY);
      volt[0] <= 8'hC0;
      cyc(10);
      rchk(ACC_OFS_FLAG, 32'(m == 1 || m == 3));
      chk(32'(irq), 32'h0);
      rchk(ACC_OFS_STATUS, 32'h1);
      wr(ACC_OFS_FLAG, 32'h0, ACC_RESP_OKAY);
      volt[0] <= 8'h40;
      cyc(10);
      rchk(ACC_OFS_FLAG, 32'(m == 2 || m == 3));
    end
    wr(ACC_OFS_CTRL1, 32'hE3, ACC_RESP_OKAY);
    cyc(10);
    rchk(ACC_OFS_STATUS, 32'h1);
    chk(32'({pin, oe}), 32'h09);
    volt[0] <= 8'hC0;
    cyc(10);
    rchk(ACC_OFS_STATUS, 32'h0);
    chk(32'({pin, oe}), 32'h01);
    wr(ACC_OFS_CTRL1, 32'hA3, ACC_RESP_OKAY);
    volt[0] <= 8'h40;
    cyc(10);
    rchk(ACC_OFS_STATUS, 32'h1);
    chk(32'({pin, oe}), 32'h00);
    wr(ACC_OFS_CTRL1, 32'h87, ACC_RESP_OKAY);
    cyc(10);
    rchk(ACC_OFS_STATUS, 32'h1);
    chk(32'(nsel), 32'h7);
    for (int u = 0; u < 3; u++)
      for (int c = 0; c < 4; c++)
      begin
        wr(cofs(u), 32'h80 | 32'(c), ACC_RESP_OKAY);
        cyc(2);
        src = (c == 3) ? 4'h8 : (c == 2) ? 4'h2 : (c == 1) ? 4'h1 : (u == 1) ? 4'h4 : 4'h2;
        chk(32'(onehot[u*4 +: 4]), 32'(src));
      end
    for (int u = 0; u < 3; u++) wr(cofs(u), 32'h80 + 32'(u), ACC_RESP_OKAY);
    for (int u = 0; u < 3; u++) rchk(cofs(u), 32'h80 + 32'(u));
    // A disabled unit with inversion set must still read low
    wr(cofs(2), 32'h20, ACC_RESP_OKAY);
    cyc(4);
    rchk(ACC_OFS_STATUS, 32'h0);
    chk(32'(en), 32'h3);
    wr(ACC_OFS_MASK, 32'h1, ACC_RESP_OKAY);
    rchk(ACC_OFS_MASK, 32'h1);
    wr(ACC_OFS_FLAG, 32'h2, ACC_RESP_OKAY);
    cyc(2);
    chk(32'(irq), 32'h0);
    wr(ACC_OFS_FLAG, 32'h1, ACC_RESP_OKAY);
    cyc(2);
    chk(32'(irq), 32'h1);
    rchk(ACC_OFS_FLAG, 32'h1);
    wr(ACC_OFS_FLAG, 32'h0, ACC_RESP_OKAY);
    cyc(2);
    chk(32'(irq), 32'h0);
    wr(8'h18, 32'h55, ACC_RESP_SLVERR);
    rd(8'h18, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(ACC_RESP_SLVERR));
    wr(ACC_OFS_STATUS, 32'h7, ACC_RESP_OKAY);
    wstrb <= 4'h0;
    wr(cofs(0), 32'hFF, ACC_RESP_OKAY);
    wstrb <= 4'hF;
    rchk(cofs(0), 32'h80);
    stop_test();
  end
endmodule : acc_top_bench

bind acc_top acc_top_assertions u_chk (.CLK(CLK), .RST(RST), .ARADDR(ARADDR),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .BRESP(BRESP), .BVALID(BVALID),
  .BREADY(BREADY), .COMPARATOR_ENABLE(COMPARATOR_ENABLE),
  .INVERTING_SOURCE_ONEHOT(INVERTING_SOURCE_ONEHOT), .RESULT_OUTPUT_PIN(RESULT_OUTPUT_PIN),
  .RESULT_OUTPUT_PIN_OE(RESULT_OUTPUT_PIN_OE));

`default_nettype wire
